// ---- bfp_counter.sv ----
// bfp_counter: loadable down counter for internal timed events
// assumes: pclk domain, load wins over count
`timescale 1ns/1ps
module bfp_counter #(
  parameter int W = 8
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  input  wire logic         run,
  output logic              done
);
  logic [W-1:0] cnt_q;

  // count down while run, done when zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= value;
    end else if (run && cnt_q != '0) begin
      cnt_q <= cnt_q - W'(1);
    end
  end
  // done reads the count only: callers build load from done, so a load term here would close a loop
  assign done = (cnt_q == '0);
endmodule : bfp_counter

// ---- bfp_device.sv ----
// bfp_device: flash write state machine for bulk factory programming
// assumes: host drives bfp_if strobes on pclk; lock and voltage inputs are synchronous
// Operation
// - three phases: setup, program-verify, exit
// - every buffer load is thirty-two words
// - array address advances to next buffer
// - host keeps first word address constant
// - host aligns first address, low bits zero
// - unaligned start aborts, sets program failure
// - one block per run, address wraps
// - host pads short buffers with all-ones
// - setup errors set failure, lock, voltage
// - ready clears during startup checks
// - reads return status; writes are data
// - bit zero set while buffer unavailable
// - program starts only when buffer full
// - foreign address exits, drops loaded data
// - writes fill consecutive positions from zero
// - writes during array programming ignored
// - host exits by all-ones other-block write
// - exit sets ready, keeps read mode
// - suspend halts, sets ready and suspended
// - suspended: only read and resume commands
// - resume continues, clears ready and suspended
// - low program voltage halts, sets error
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ps
module bfp_device
  import bfp_pkg::*;
#(
  parameter int BLOCK_BITS = BLK_W,
  parameter int SETUP_CYCLES = SETUP_CYC,
  parameter int PROG_CYCLES  = WORD_PROG_CYC
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  bfp_if.dev              bus,
  input  wire logic       block_locked,    // target block lock bit
  input  wire logic       vpp_low,         // supply at or below lockout level
  input  wire logic       vpp_factory,     // supply at factory level
  output logic            array_we,        // array word write strobe
  output logic [ADDR_W-1:0] array_addr,
  output logic [DATA_W-1:0] array_data,
  output logic [7:0]      status
);
  import bfp_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum {S_IDLE, S_ARMED, S_SETUP, S_LOAD, S_PROG, S_SUSP} bfp_state_e;
  bfp_state_e state_q;

  logic [DATA_W-1:0]  buf_q [BUF_WORDS];
  logic [BUF_W-1:0]   fill_q;              // next buffer position
  logic [BUF_W-1:0]   prog_q;              // word being programmed
  logic [ADDR_W-1:0]  base_q;              // first word address
  logic [BLOCK_BITS-1:0] off_q;            // offset inside the block
  logic [7:0]         status_q;
  logic               read_status_q;       // read mode: status vs array
  logic [ADDR_W-1:0]  array_addr_q;
  logic [DATA_W-1:0]  array_data_q;
  logic               array_we_q;
  logic [DATA_W-1:0]  rdata_q;
  logic               rvalid_q;
  logic               tmr_load;
  logic [15:0]        tmr_val;
  logic               tmr_done;

  logic [7:0] cmd;
  logic       same_blk;
  assign cmd      = bus.wdata[7:0];
  assign same_blk = bus.addr[ADDR_W-1:BLOCK_BITS] == base_q[ADDR_W-1:BLOCK_BITS];

  bfp_counter #(.W(16)) u_tmr (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (tmr_load),
    .value   (tmr_val),
    .run     (state_q != S_SUSP),
    .done    (tmr_done)
  );

  // timer loads on entry to setup, on entry to program and on each word programmed but the last
  always_comb begin
    tmr_load = 1'b0;
    tmr_val  = 16'(PROG_CYCLES);
    if (state_q == S_ARMED && bus.wr_stb && cmd == CMD_BFP_CONFIRM) begin
      tmr_load = 1'b1;
      tmr_val  = 16'(SETUP_CYCLES);
    end else if (state_q == S_LOAD && bus.wr_stb && same_blk && fill_q == BUF_W'(BUF_WORDS-1)) begin
      tmr_load = 1'b1;
    end else if (state_q == S_PROG && tmr_done && prog_q != BUF_W'(BUF_WORDS-1)) begin
      tmr_load = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // sequencer and status
  // ----------------------------------------------------------------
  // whole write state machine; status bits change with the phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q       <= S_IDLE;
      status_q      <= STATUS_RST;
      fill_q        <= '0;
      prog_q        <= '0;
      base_q        <= '0;
      off_q         <= '0;
      read_status_q <= 1'b0;
      array_we_q    <= 1'b0;
      array_addr_q  <= '0;
      array_data_q  <= '0;
    end else begin
      array_we_q <= 1'b0;
      unique case (state_q)
        S_IDLE: begin
          if (bus.wr_stb) begin
            if (cmd == CMD_BFP_SETUP) begin
              state_q       <= S_ARMED;
              read_status_q <= 1'b1;
            end else if (cmd == CMD_READ_ARRAY) begin
              read_status_q <= 1'b0;
            end else if (cmd == CMD_READ_STATUS) begin
              read_status_q <= 1'b1;
            end else if (cmd == CMD_CLR_STATUS) begin
              status_q <= STATUS_RST;
            end
          end
        end
        S_ARMED: begin
          if (bus.wr_stb) begin
            if (cmd == CMD_BFP_CONFIRM) begin
              state_q            <= S_SETUP;
              base_q             <= bus.addr;
              off_q              <= bus.addr[BLOCK_BITS-1:0];
              status_q[SB_READY] <= 1'b0;
              status_q[SB_BUSY0] <= 1'b1;                    // buffer not free during checks
            end else begin
              state_q <= S_IDLE;
            end
          end
        end
        S_SETUP: begin
          // startup checks; errors end the run with ready back
          if (tmr_done) begin
            if (block_locked || vpp_low || !vpp_factory || base_q[BUF_W-1:0] != '0) begin
              status_q[SB_PFAIL] <= 1'b1;
              status_q[SB_LOCK]  <= block_locked;
              status_q[SB_VPP]   <= vpp_low || !vpp_factory;
              status_q[SB_READY] <= 1'b1;
              status_q[SB_BUSY0] <= 1'b0;
              state_q            <= S_IDLE;
            end else begin
              status_q[SB_BUSY0] <= 1'b0;                    // buffer available
              fill_q             <= '0;
              state_q            <= S_LOAD;
            end
          end
        end
        S_LOAD: begin
          // every in-block write is data, even a status command
          if (bus.wr_stb) begin
            if (!same_blk) begin
              fill_q             <= '0;                      // loaded words dropped
              status_q[SB_READY] <= 1'b1;
              state_q            <= S_IDLE;                  // read mode untouched
            end else begin
              fill_q <= fill_q + BUF_W'(1);
              if (fill_q == BUF_W'(BUF_WORDS-1)) begin
                status_q[SB_BUSY0] <= 1'b1;
                prog_q             <= '0;
                state_q            <= S_PROG;
              end
            end
          end
        end
        S_PROG: begin
          // writes other than suspend are ignored while programming
          if (bus.wr_stb && cmd == CMD_SUSPEND) begin
            status_q[SB_READY] <= 1'b1;
            status_q[SB_SUSP]  <= 1'b1;
            state_q            <= S_SUSP;
          end else if (vpp_low) begin
            status_q[SB_VPP]   <= 1'b1;
            status_q[SB_PFAIL] <= 1'b1;
            status_q[SB_READY] <= 1'b1;
            state_q            <= S_IDLE;
          end else if (tmr_done) begin
            array_we_q   <= 1'b1;
            array_addr_q <= {base_q[ADDR_W-1:BLOCK_BITS], off_q};
            array_data_q <= buf_q[prog_q];
            off_q        <= off_q + BLOCK_BITS'(1);          // wraps in block
            prog_q       <= prog_q + BUF_W'(1);
            if (prog_q == BUF_W'(BUF_WORDS-1)) begin
              status_q[SB_BUSY0] <= 1'b0;
              fill_q             <= '0;
              state_q            <= S_LOAD;
            end
          end
        end
        S_SUSP: begin
          // only reads and resume are honoured here
          if (bus.wr_stb) begin
            if (cmd == CMD_RESUME) begin
              status_q[SB_READY] <= 1'b0;
              status_q[SB_SUSP]  <= 1'b0;
              state_q            <= S_PROG;
            end else if (cmd == CMD_READ_ARRAY) begin
              read_status_q <= 1'b0;
            end else if (cmd == CMD_READ_STATUS || cmd == CMD_READ_ID || cmd == CMD_CFI_QUERY) begin
              read_status_q <= 1'b1;
            end
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // buffer storage, written only while loading in-block
  always_ff @(posedge pclk) begin
    if (state_q == S_LOAD && bus.wr_stb && same_blk) begin
      buf_q[fill_q] <= bus.wdata;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // inside a run every read gives status; array contents are outside this block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= bus.rd_stb;
      if (bus.rd_stb) begin
        rdata_q <= (read_status_q || state_q != S_IDLE) ? {8'h00, status_q} : FILL_WORD;
      end
    end
  end

  assign bus.rdata  = rdata_q;
  assign bus.rvalid = rvalid_q;
  assign array_we   = array_we_q;
  assign array_addr = array_addr_q;
  assign array_data = array_data_q;
  assign status     = status_q;
endmodule : bfp_device

// ---- bfp_host.sv ----
// bfp_host: apb-controlled programmer driving the flash bus
// assumes: device answers reads one cycle after rd_stb
`timescale 1ns/1ps
module bfp_host
  import bfp_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  bfp_if.host              bus
);
  import bfp_pkg::*;

  logic [ADDR_W-1:0] fwa_q;     // first word address, held through the run
  logic [ADDR_W-1:0] exita_q;
  logic              wr_q, rd_q, wait_q, pready_q, pslverr_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [31:0]       prdata_q;
  logic              acc;
  assign acc = psel && penable && !pready_q;

  // ----------------------------------------------------------------
  // apb slave and flash strobes
  // ----------------------------------------------------------------
  // one wait cycle on writes and non-status reads, status reads wait for the device answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwa_q     <= '0;
      exita_q   <= '0;
      wr_q      <= 1'b0;
      rd_q      <= 1'b0;
      wait_q    <= 1'b0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      addr_q    <= '0;
      wdata_q   <= '0;
      prdata_q  <= '0;
    end else begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      pready_q <= 1'b0;
      if (bus.rvalid) begin
        prdata_q <= {24'h0, bus.rdata[7:0]};
        pready_q <= 1'b1;
        wait_q   <= 1'b0;
      end else if (acc && !wait_q) begin
        pslverr_q <= 1'b0;
        if (pwrite) begin
          pready_q <= 1'b1;
          unique case (paddr)
            REG_ADDR:  fwa_q   <= pwdata[ADDR_W-1:0];
            REG_EXITA: exita_q <= pwdata[ADDR_W-1:0];
            REG_DATA: begin
              wr_q    <= 1'b1;
              addr_q  <= fwa_q;
              wdata_q <= pwdata[DATA_W-1:0];
            end
            REG_CTRL: begin
              wr_q <= 1'b1;
              addr_q <= pwdata[CT_EXIT] ? exita_q : fwa_q;
              wdata_q <= pwdata[CT_EXIT] ? FILL_WORD :
                         pwdata[CT_SUSP] ? DATA_W'(CMD_SUSPEND) :
                         pwdata[CT_RES]  ? DATA_W'(CMD_RESUME) : DATA_W'(CMD_BFP_SETUP);
            end
            default: pslverr_q <= 1'b1;
          endcase
        end else if (paddr == REG_STATUS) begin
          rd_q   <= 1'b1;                                 // reads return status
          addr_q <= fwa_q;
          wait_q <= 1'b1;
        end else begin
          pready_q  <= 1'b1;
          prdata_q  <= '0;
          pslverr_q <= paddr != REG_ADDR && paddr != REG_EXITA && paddr != REG_CTRL && paddr != REG_DATA;
        end
      end
    end
  end

  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign bus.wr_stb = wr_q;
  assign bus.rd_stb = rd_q;
  assign bus.addr   = addr_q;
  assign bus.wdata  = wdata_q;
endmodule : bfp_host

// ---- bfp_if.sv ----
// bfp_if: flash write/read bus between controller and device
// assumes: single pclk domain, device answers every read strobe in one cycle
`timescale 1ns/1ps
interface bfp_if;
  import bfp_pkg::*;
  logic                 wr_stb;     // one-cycle write strobe
  logic                 rd_stb;     // one-cycle read strobe
  logic [ADDR_W-1:0]    addr;
  logic [DATA_W-1:0]    wdata;
  logic [DATA_W-1:0]    rdata;      // valid cycle after rd_stb
  logic                 rvalid;

  modport dev  (input wr_stb, input rd_stb, input addr, input wdata, output rdata, output rvalid);
  modport host (output wr_stb, output rd_stb, output addr, output wdata, input rdata, input rvalid);
endinterface : bfp_if

// ---- bfp_pkg.sv ----
// bfp_pkg: shared constants and types for the bulk factory program sequencer
// assumes: included first in compile order, used by interface and both ends
package bfp_pkg;

  // ----------------------------------------------------------------
  // link widths
  // ----------------------------------------------------------------
  localparam int ADDR_W   = 23;
  localparam int DATA_W   = 16;
  localparam int BUF_W    = 5;                  // buffer index width
  localparam int BUF_WORDS = 32;                // words per buffer load
  localparam int BLK_W    = 16;                 // word-address bits inside a block

  // ----------------------------------------------------------------
  // command codes (values arbitrary, coded here only)
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_BFP_SETUP   = 8'h80;
  localparam logic [7:0] CMD_BFP_CONFIRM = 8'hd0;
  localparam logic [7:0] CMD_SUSPEND     = 8'hb0;
  localparam logic [7:0] CMD_RESUME      = 8'hd0;
  localparam logic [7:0] CMD_READ_ARRAY  = 8'hff;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_READ_ID     = 8'h90;
  localparam logic [7:0] CMD_CFI_QUERY   = 8'h98;
  localparam logic [7:0] CMD_CLR_STATUS  = 8'h50;
  localparam logic [DATA_W-1:0] FILL_WORD = 16'hffff;

  // ----------------------------------------------------------------
  // status bit positions
  // ----------------------------------------------------------------
  localparam int SB_BUSY0  = 0;
  localparam int SB_LOCK   = 1;
  localparam int SB_SUSP   = 2;
  localparam int SB_VPP    = 3;
  localparam int SB_PFAIL  = 4;
  localparam int SB_READY  = 7;
  localparam logic [7:0] STATUS_RST = 8'h80;

  // ----------------------------------------------------------------
  // timing counts
  // ----------------------------------------------------------------
  localparam int CLK_NS        = 25;
  localparam int SETUP_NS      = 1000;           // startup checks
  localparam int SETUP_CYC     = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WORD_PROG_NS  = 200;            // per-word array program
  localparam int WORD_PROG_CYC = (WORD_PROG_NS + CLK_NS - 1) / CLK_NS;

  // ----------------------------------------------------------------
  // apb register map of the controller
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;     // w: bit0 start, bit1 exit, bit2 suspend, bit3 resume
  localparam logic [7:0] REG_ADDR   = 8'h04;     // first word address
  localparam logic [7:0] REG_DATA   = 8'h08;     // buffer data word (w)
  localparam logic [7:0] REG_STATUS = 8'h0c;     // r: last device status byte
  localparam logic [7:0] REG_EXITA  = 8'h10;     // address in another block for exit
  localparam int CT_START = 0;
  localparam int CT_EXIT  = 1;
  localparam int CT_SUSP  = 2;
  localparam int CT_RES   = 3;

  typedef enum logic [1:0] {BFP_BUS_IDLE, BFP_BUS_WR, BFP_BUS_RD} bfp_op_e;

endpackage : bfp_pkg

// ---- bfp_props.sv ----
// bfp_props: checks on the flash link and device status between the two ends
// assumes: placed in the bench beside bfp_if, a single pclk domain
`timescale 1ns/1ps
module bfp_props (
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic                        wr_stb,
  input wire logic                        rd_stb,
  input wire logic [bfp_pkg::ADDR_W-1:0]  addr,
  input wire logic [bfp_pkg::DATA_W-1:0]  wdata,
  input wire logic [bfp_pkg::DATA_W-1:0]  rdata,
  input wire logic                        rvalid,
  input wire logic                        array_we,
  input wire logic [7:0]                  status
);
  import bfp_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // link handshake
  // ----------------------------------------------------------------
  property p_rd_answer; rd_stb |=> rvalid; endproperty
  property p_rv_cause; rvalid |-> $past(rd_stb); endproperty
  property p_one_op; !(wr_stb && rd_stb); endproperty
  property p_wr_pulse; wr_stb |=> !wr_stb; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read strobe not answered next cycle");
  a_rv_cause: assert property (p_rv_cause) else $error("read answer without a read strobe");
  a_one_op: assert property (p_one_op) else $error("read and write strobes together");
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe longer than one cycle");

  // ----------------------------------------------------------------
  // status coherence; error bits never stand without the failure bit
  // ----------------------------------------------------------------
  // array strobe lags its launch by one edge; the last word lands as busy drops
  property p_busy_prog; array_we |-> $past(status[SB_BUSY0]); endproperty
  property p_prog_notready; array_we |-> !status[SB_READY]; endproperty
  property p_susp_ready; status[SB_SUSP] |-> status[SB_READY]; endproperty
  property p_lock_fail; status[SB_LOCK] |-> status[SB_PFAIL]; endproperty
  property p_vpp_fail; $rose(status[SB_VPP]) |-> status[SB_PFAIL] && !array_we; endproperty
  a_busy_prog: assert property (p_busy_prog) else $error("array write while buffer shown free");
  a_prog_notready: assert property (p_prog_notready) else $error("array write while ready");
  a_susp_ready: assert property (p_susp_ready) else $error("suspended without ready");
  a_lock_fail: assert property (p_lock_fail) else $error("lock error without failure");
  a_vpp_fail: assert property (p_vpp_fail) else $error("voltage error without failure");

  c_prog: cover property (array_we);
  c_susp: cover property (status[SB_SUSP]);
  c_fail: cover property (status[SB_PFAIL] && status[SB_READY]);
endmodule : bfp_props

// ---- bfp_tb_top.sv ----
// bfp_tb_top: drives the host over apb, joins host and device, checks array writes
// assumes: device built with a 64-word block and short setup and word times
`timescale 1ns/1ps
module bfp_tb_top;
  import bfp_pkg::*;
  localparam logic [ADDR_W-1:0] BASE = 23'h000040;  // low five bits zero
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q;
  logic [7:0]        paddr, status;
  logic [31:0]       pwdata, prdata, rd_q, seed;
  logic              block_locked, vpp_low, vpp_factory, array_we;
  logic [ADDR_W-1:0] array_addr;
  logic [DATA_W-1:0] array_data;
  logic [ADDR_W-1:0] got_a[$];
  logic [DATA_W-1:0] got_d[$];
  logic [DATA_W-1:0] buf_d[32];
  logic [7:0]        exp_e[4];
  int                failures, tests_run;

  bfp_if bfp_if_i ();
  bfp_device #(.BLOCK_BITS(6), .SETUP_CYCLES(4), .PROG_CYCLES(2)) bfp_device_i (
    .pclk(pclk), .presetn(presetn), .bus(bfp_if_i), .block_locked(block_locked), .vpp_low(vpp_low),
    .vpp_factory(vpp_factory), .array_we(array_we), .array_addr(array_addr), .array_data(array_data),
    .status(status));
  bfp_host bfp_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(bfp_if_i));
  bfp_props bfp_props_i (.pclk(pclk), .presetn(presetn), .wr_stb(bfp_if_i.wr_stb), .rd_stb(bfp_if_i.rd_stb),
    .addr(bfp_if_i.addr), .wdata(bfp_if_i.wdata), .rdata(bfp_if_i.rdata), .rvalid(bfp_if_i.rvalid),
    .array_we(array_we), .status(status));

  // ----------------------------------------------------------------
  // clock, array write monitor, watchdog
  // ----------------------------------------------------------------
  initial pclk = 1'b0;
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (array_we === 1'b1) begin
      got_a.push_back(array_addr);
      got_d.push_back(array_data);
    end
  end
  initial begin
    repeat (40000) @(posedge pclk);
    failures++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h000000c5 : 32'h0);
  endfunction : lfsr
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // apb master; holds the request until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 100);
    if (n >= 100) failures++;
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic poll(input logic [7:0] mask, input logic [7:0] val);
    int n;
    n = 0;
    do begin apb(1'b0, REG_STATUS, 32'h0); n++; end while ((rd_q[7:0] & mask) !== val && n < 300);
    if (n >= 300) failures++;
  endtask : poll
  task automatic start_run(input logic [ADDR_W-1:0] a);
    apb(1'b1, REG_ADDR, 32'(a));
    apb(1'b1, REG_CTRL, 32'h1 << CT_START);
    apb(1'b1, REG_DATA, 32'(CMD_BFP_CONFIRM));
  endtask : start_run
  // random buffer words, remembered for the array comparison
  task automatic fill(input int first, input int n);
    for (int i = first; i < first + n; i++) begin
      seed = lfsr(seed);
      buf_d[i] = seed[15:0];
      apb(1'b1, REG_DATA, {16'h0, seed[15:0]});
    end
  endtask : fill
  task automatic expect_buf(input logic [ADDR_W-1:0] a);
    check(32'(got_a.size()), 32'd32);
    if (got_a.size() == 32) begin
      for (int i = 0; i < 32; i++) begin
        check(32'(got_a.pop_front()), 32'(a) + i);
        check(32'(got_d.pop_front()), 32'(buf_d[i]));
      end
    end
  endtask : expect_buf
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h054c; failures = 0; tests_run = 0; presetn = 1'b0;
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0; pwdata = 32'h0;
    block_locked = 1'b0; vpp_low = 1'b0; vpp_factory = 1'b1;
    exp_e = '{8'h10, 8'h12, 8'h18, 8'h18};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check(32'(status), 32'(STATUS_RST));
    apb(1'b0, 8'h20, 32'h0);
    check(32'(err_q), 32'h1);
    $display("test reset and map done");
    // first buffer, one word short, then a stray write behind it
    start_run(BASE);
    apb(1'b0, REG_STATUS, 32'h0);
    check(32'(rd_q[7]), 32'h0);
    poll(8'h01, 8'h00);
    fill(0, 31);
    repeat (6) @(posedge pclk);
    check(32'(got_a.size()), 32'h0);
    fill(31, 1);
    apb(1'b1, REG_DATA, 32'h1234);
    poll(8'h01, 8'h00);
    expect_buf(BASE);
    $display("test first buffer done");
    // second buffer, suspended mid-program; nothing may reach the array meanwhile
    fill(0, 32);
    apb(1'b1, REG_CTRL, 32'h1 << CT_SUSP);
    poll(8'h04, 8'h04);
    check(32'(rd_q[7:0] & 8'h84), 32'h84);
    // a setup command while suspended must be ignored
    apb(1'b1, REG_CTRL, 32'h1 << CT_START);
    apb(1'b0, REG_STATUS, 32'h0);
    check(32'(rd_q[7:0] & 8'h84), 32'h84);
    begin
      int n0;
      n0 = got_a.size();
      repeat (20) @(posedge pclk);
      check(32'(got_a.size()), 32'(n0));
    end
    apb(1'b1, REG_CTRL, 32'h1 << CT_RES);
    apb(1'b0, REG_STATUS, 32'h0);
    check(32'(rd_q[7:0] & 8'h84), 32'h0);
    poll(8'h01, 8'h00);
    expect_buf(BASE + 23'd32);
    $display("test suspend and resume done");
    // third buffer starts at the block base after the offset wraps past the 64-word block; short data padded with all-ones
    fill(0, 20);
    for (int i = 20; i < 32; i++) begin
      buf_d[i] = FILL_WORD;
      apb(1'b1, REG_DATA, 32'(FILL_WORD));
    end
    poll(8'h01, 8'h00);
    expect_buf(BASE);
    // partial fill abandoned by leaving for another block
    fill(0, 10);
    apb(1'b1, REG_EXITA, 32'(BASE + 23'd64));
    apb(1'b1, REG_CTRL, 32'h1 << CT_EXIT);
    poll(8'h80, 8'h80);
    check(32'(got_a.size()), 32'h0);
    check(32'(rd_q[4]), 32'h0);
    $display("test wrap and exit done");
    // setup errors and low supply, each from a fresh reset
    for (int k = 0; k < 4; k++) begin
      presetn <= 1'b0;
      block_locked <= (k == 1);
      vpp_low <= (k == 2);
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      got_a.delete();
      got_d.delete();
      start_run(k == 0 ? BASE + 23'd3 : BASE);
      if (k == 3) begin
        poll(8'h01, 8'h00);
        fill(0, 32);
        vpp_low <= 1'b1;
      end
      poll(8'h80, 8'h80);
      check(32'(rd_q[7:0] & 8'h1a), 32'(exp_e[k]));
    end
    $display("test setup errors done");
    tally_and_finish();
  end
endmodule : bfp_tb_top
